// >>> verilog/bsdc_top.v
// Purpose: battery-short diagnostic control and event logic for two sense inputs
// Assumes: serial port core presents decoded sub map accesses as strobes
// Notes: status bits are write-1-to-clear; an active event keeps its bit set
`timescale 1ns/1ps
`include "bsdc_regs.vh"
module bsdc_top (
   // clock and reset
   input wire clk_sys_in,
   input wire reset_n_in,
   // register port
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_write_in,
   input wire reg_read_in,
   output wire [7:0] reg_rdata_out,
   // comparators
   input wire first_sense_input_in,
   input wire second_sense_input_in,
   output wire first_slicer_power_off_out,
   output wire second_slicer_power_off_out,
   output wire [2:0] first_threshold_code_out,
   output wire [2:0] second_threshold_code_out,
   // interrupt
   output wire interrupt_request_out
);
   reg [1:0] power_off_q;
   reg [2:0] level0_q;
   reg [2:0] level1_q;
   reg [7:0] rdata_q;
   reg [7:0] rdata_d;
   wire [1:0] comp_in;
   wire [1:0] flag;
   wire [1:0] clear;
   wire wr_first;
   wire wr_second;
   wire wr_status;

   function hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // ****************************************
   // control registers
   // ****************************************
   assign wr_first = reg_write_in & hit(reg_addr_in, `BSDC_FIRST_CTRL_ADDR);
   assign wr_second = reg_write_in & hit(reg_addr_in, `BSDC_SECOND_CTRL_ADDR);
   assign wr_status = reg_write_in & hit(reg_addr_in, `BSDC_STATUS_ADDR);

   always @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         power_off_q <= {2{`BSDC_PWR_OFF_RST}};
         level0_q <= `BSDC_LEVEL_RST;
         level1_q <= `BSDC_LEVEL_RST;
      end else begin
         if (wr_first) begin
            power_off_q[0] <= reg_wdata_in[`BSDC_PWR_OFF_BIT];
            level0_q <= reg_wdata_in[`BSDC_LEVEL_MSB:`BSDC_LEVEL_LSB];
         end
         if (wr_second) begin
            power_off_q[1] <= reg_wdata_in[`BSDC_PWR_OFF_BIT];
            level1_q <= reg_wdata_in[`BSDC_LEVEL_MSB:`BSDC_LEVEL_LSB];
         end
      end
   end

   // the slicer only honours its code while powered up, so both go out as stored
   assign first_slicer_power_off_out = power_off_q[0];
   assign second_slicer_power_off_out = power_off_q[1];
   assign first_threshold_code_out = level0_q;
   assign second_threshold_code_out = level1_q;

   // ****************************************
   // sense channels
   // ****************************************
   assign comp_in = {second_sense_input_in, first_sense_input_in};
   assign clear[0] = wr_status & reg_wdata_in[`BSDC_STAT_FIRST_BIT];
   assign clear[1] = wr_status & reg_wdata_in[`BSDC_STAT_SECOND_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
         bsdc_sense_chan u_chan (
            .clk_sys_in(clk_sys_in),
            .reset_n_in(reset_n_in),
            .comp_above_in(comp_in[gi]),
            .power_off_in(power_off_q[gi]),
            .clear_in(clear[gi]),
            .flag_out(flag[gi])
         );
      end
   endgenerate

   // level request, held until software clears the cause
   assign interrupt_request_out = flag[0] | flag[1];

   // ****************************************
   // read back
   // ****************************************
   always @* begin
      rdata_d = 8'h00;
      if (hit(reg_addr_in, `BSDC_FIRST_CTRL_ADDR)) begin
         rdata_d[`BSDC_PWR_OFF_BIT] = power_off_q[0];
         rdata_d[`BSDC_LEVEL_MSB:`BSDC_LEVEL_LSB] = level0_q;
      end else if (hit(reg_addr_in, `BSDC_SECOND_CTRL_ADDR)) begin
         rdata_d[`BSDC_PWR_OFF_BIT] = power_off_q[1];
         rdata_d[`BSDC_LEVEL_MSB:`BSDC_LEVEL_LSB] = level1_q;
      end else if (hit(reg_addr_in, `BSDC_STATUS_ADDR)) begin
         rdata_d[`BSDC_STAT_FIRST_BIT] = flag[0];
         rdata_d[`BSDC_STAT_SECOND_BIT] = flag[1];
      end
   end

   always @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_q <= `BSDC_RDATA_RST;
      end else if (reg_read_in) begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;
endmodule // bsdc_top

// >>> verilog/bsdc_regs.vh
// Purpose: constants of the battery-short diagnostic control block
// Assumes: 8-bit sub map registers reached through the device's serial register port
// Notes: offsets are sub map addresses; bits not listed read as zero
`ifndef BSDC_REGS_VH
`define BSDC_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define BSDC_FIRST_CTRL_ADDR 8'h5D
`define BSDC_SECOND_CTRL_ADDR 8'h5E
`define BSDC_STATUS_ADDR 8'h5F

// ****************************************
// field positions
// ****************************************
`define BSDC_PWR_OFF_BIT 6
`define BSDC_LEVEL_MSB 4
`define BSDC_LEVEL_LSB 2
`define BSDC_STAT_FIRST_BIT 0
`define BSDC_STAT_SECOND_BIT 1

// ****************************************
// reset values
// ****************************************
`define BSDC_PWR_OFF_RST 1'b1
`define BSDC_LEVEL_RST 3'h3
`define BSDC_RDATA_RST 8'h00

`endif

// >>> verilog/bsdc_sense_chan.v
// Purpose: one sense channel: comparator synchroniser, gating and sticky event flag
// Assumes: comparator output is asynchronous to clk_sys_in
// Notes: flag is set by hardware, cleared by clear_in; set wins
`timescale 1ns/1ps
`include "bsdc_regs.vh"
module bsdc_sense_chan (
   // clock and reset
   input wire clk_sys_in,
   input wire reset_n_in,
   // analog side
   input wire comp_above_in,
   input wire power_off_in,
   // register side
   input wire clear_in,
   output wire flag_out
);
   reg sync1_q;
   reg sync2_q;
   reg off1_q;
   reg off2_q;
   reg flag_q;
   wire event_d;

   // ****************************************
   // synchroniser
   // ****************************************
   always @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         off1_q <= `BSDC_PWR_OFF_RST;
         off2_q <= `BSDC_PWR_OFF_RST;
      end else begin
         sync1_q <= comp_above_in;
         sync2_q <= sync1_q;
         off1_q <= power_off_in;
         off2_q <= off1_q;
      end
   end

   // powered-down slicer output is meaningless, so it is masked
   // samples taken before power-up still sit in the synchroniser
   assign event_d = sync2_q & ~(power_off_in | off1_q | off2_q);

   // ****************************************
   // sticky flag
   // ****************************************
   always @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         flag_q <= 1'b0;
      end else if (event_d) begin
         flag_q <= 1'b1;
      end else if (clear_in) begin
         flag_q <= 1'b0;
      end
   end

   assign flag_out = flag_q;
endmodule // bsdc_sense_chan

// >>> test/bsdc_comp_model.sv
// Purpose: behavioural comparator for one sense pin
// Assumes: pin level given in mV by the bench
// Notes: none
`timescale 1ns/1ps
module bsdc_comp_model (
   input wire logic [2:0] code_in,
   input wire logic power_off_in,
   input wire logic [15:0] level_mv_in,
   output logic above_out
);
   // a dead slicer shows 1, so a missing gate in the block is seen
   assign above_out = power_off_in | (level_mv_in > 75 + 150 * code_in);
endmodule // bsdc_comp_model

// >>> test/bsdc_checker.sv
// Purpose: port assertions of the battery-short block
// Assumes: one clock domain
// Notes: bound in tb_top
`timescale 1ns/1ps
module bsdc_checker (
   // clock, reset and register port
   input wire logic clk_sys_in, reset_n_in, reg_write_in, reg_read_in,
   input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
   // comparators and interrupt
   input wire logic first_sense_input_in, second_sense_input_in, interrupt_request_out,
   input wire logic first_slicer_power_off_out, second_slicer_power_off_out,
   input wire logic [2:0] first_threshold_code_out, second_threshold_code_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   wire w1 = reg_write_in && reg_addr_in == 8'h5D;
   wire w2 = reg_write_in && reg_addr_in == 8'h5E;
   wire off2 = first_slicer_power_off_out && second_slicer_power_off_out;
   wire on1 = !first_slicer_power_off_out && first_sense_input_in;
   wire on2 = !second_slicer_power_off_out && second_sense_input_in;
   AST_PWR1: assert property (w1 |=> first_slicer_power_off_out == $past(reg_wdata_in[6]))
      else $error("power-off one wrong");
   AST_PWR2: assert property (w2 |=> second_slicer_power_off_out == $past(reg_wdata_in[6]))
      else $error("power-off two wrong");
   AST_LVL1: assert property (w1 |=> first_threshold_code_out == $past(reg_wdata_in[4:2]))
      else $error("code one wrong");
   AST_LVL2: assert property (w2 |=> second_threshold_code_out == $past(reg_wdata_in[4:2]))
      else $error("code two wrong");
   AST_EV1: assert property (on1 [*3] |=> interrupt_request_out)
      else $error("event one missed");
   AST_EV2: assert property (on2 [*3] |=> interrupt_request_out)
      else $error("event two missed");
   AST_OFF: assert property ($rose(interrupt_request_out) |->
      !$past(off2) || !$past(off2, 2) || !$past(off2, 3)) else $error("event while off");
   AST_HOLD: assert property (interrupt_request_out && !(reg_write_in && reg_addr_in == 8'h5F)
      |=> interrupt_request_out) else $error("interrupt dropped");
   AST_STAT: assert property (reg_read_in && reg_addr_in == 8'h5F |=>
      (reg_rdata_out[1:0] != 0) == $past(interrupt_request_out)) else $error("status wrong");
endmodule // bsdc_checker

// >>> test/tb_top.sv
// Purpose: self-checking bench of the battery-short block
// Assumes: comparator models on both sense pins
// Notes: seed 36
`timescale 1ns/1ps
module tb_top;
   logic clk_sys_in = 0, reset_n_in = 0, wr = 0, rd = 0, s1, s2, p1, p2, irq;
   logic [7:0] addr = 0, wd = 0, rdat, a, v;
   logic [2:0] c1, c2, c;
   logic [15:0] mv [2] = '{16'h07D0, 16'h07D0};
   int bad_count = 0, n_checks = 0, k;
   initial forever #25 clk_sys_in = ~clk_sys_in;
   bsdc_top i_bsdc_top (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .reg_addr_in(addr), .reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd),
      .reg_rdata_out(rdat), .first_sense_input_in(s1), .second_sense_input_in(s2),
      .first_slicer_power_off_out(p1), .second_slicer_power_off_out(p2),
      .first_threshold_code_out(c1), .second_threshold_code_out(c2),
      .interrupt_request_out(irq));
   bsdc_comp_model i_cmp1 (.code_in(c1), .power_off_in(p1), .level_mv_in(mv[0]), .above_out(s1));
   bsdc_comp_model i_cmp2 (.code_in(c2), .power_off_in(p2), .level_mv_in(mv[1]), .above_out(s2));
   task automatic chk(input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic acc(input logic [7:0] ad, d, input logic w);
      @(negedge clk_sys_in); addr = ad; wd = d; wr = w; rd = !w;
      @(negedge clk_sys_in); wr = 0; rd = 0;
   endtask
   task automatic wait_irq(input logic e);
      for (int i = 0; i < 8 && irq !== e; i++) @(negedge clk_sys_in);
      chk({7'h0, irq}, {7'h0, e});
      if (irq !== e) report_and_stop;
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      k = $urandom(36);
      repeat (6) @(negedge clk_sys_in);
      reset_n_in = 1;
      acc(8'h5D, 0, 0); chk(rdat, 8'h4C);
      acc(8'h5E, 0, 0); chk(rdat, 8'h4C);
      acc(8'h60, 0, 0); chk(rdat, 8'h00);
      for (k = 0; k < 16; k++) begin
         a = 8'h5D + k[0]; v = $urandom;
         acc(a, v, 1); acc(a, 0, 0); chk(rdat, v & 8'h5C);
      end
      acc(8'h5D, 8'h40, 1); acc(8'h5E, 8'h40, 1);
      acc(8'h5F, 8'h03, 1);
      repeat (6) @(negedge clk_sys_in);
      wait_irq(0);
      for (k = 0; k < 2; k++) begin
         c = $urandom; a = 8'h5D + k[0];
         acc(a, {3'h0, c, 2'h0}, 1);
         mv[k] = 75 + 150 * c; repeat (6) @(negedge clk_sys_in);
         wait_irq(0);
         mv[k] = mv[k] + 1; wait_irq(1);
         acc(8'h5F, 0, 0); chk(rdat, 8'h01 << k);
         acc(8'h5F, 8'h01 << k, 1); wait_irq(1);
         mv[k] = 0; repeat (4) @(negedge clk_sys_in);
         acc(8'h5F, 8'h01 << k, 1); wait_irq(0);
         acc(a, 8'h40, 1);
      end
      report_and_stop;
   end
endmodule // tb_top
bind bsdc_top bsdc_checker i_bsdc_checker (.*);
